// >>> process_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module process_side_model (
  // clock
  input  wire logic               clk_sys,
  // commands from the bench
  input  wire logic signed [15:0] pv_goal,
  input  wire logic               fault_req,
  input  wire logic               press_go,
  input  wire logic [15:0]        press_len,
  // toward the block
  output logic signed [15:0]      pv,
  output logic                    sensor_fault,
  output logic                    key_in
);
  logic [15:0] held_r;

  initial begin
    pv = 16'sh0000;
    sensor_fault = 1'b0;
    held_r = 16'h0000;
  end

  // plant has inertia: pv creeps one count a cycle, never jumps to goal
  always @(negedge clk_sys) begin
    if (pv < pv_goal) pv <= pv + 16'sh0001;
    else if (pv > pv_goal) pv <= pv - 16'sh0001;
    sensor_fault <= fault_req;
    if (press_go) held_r <= press_len;
    else if (held_r != 16'h0000) held_r <= held_r - 16'h0001;
  end

  assign key_in = (held_r != 16'h0000);
endmodule
`default_nettype wire

// >>> sup_cfg.svh
`ifndef SUP_CFG_SVH
`define SUP_CFG_SVH

// ----------------------------------------
// clock and derived rates
// ----------------------------------------
`define SUP_CLK_KHZ       200000
`define SUP_TICK_MS       1
`define SUP_CYC_PER_MS    (`SUP_TICK_MS * `SUP_CLK_KHZ)
`define SUP_MS_PER_S      1000
`define SUP_S_PER_MIN     60

// ----------------------------------------
// key timing, in ms ticks
// ----------------------------------------
`define SUP_KEY_SHORT_MS  1000
`define SUP_KEY_LONG_MS   3000

// ----------------------------------------
// lamp flash rates, in ms ticks
// ----------------------------------------
`define SUP_FLASH_SLOW_MS 500
`define SUP_FLASH_FAST_MS 125

// ----------------------------------------
// output percentages and loop break
// ----------------------------------------
`define SUP_PCT_FULL      7'h64
`define SUP_PCT_HALF      7'h32
`define SUP_LBD_PV_DELTA  16'h0002

// ----------------------------------------
// reset values
// ----------------------------------------
`define SUP_RUN_RST       1'b0
`define SUP_BLOCK_RST     2'h3

`endif

// >>> sup_pkg.sv
package sup_pkg;

  localparam int FUNC_W = 3;
  localparam int NAL    = 2;

  typedef enum logic [1:0] {
    TRIG_OFF, TRIG_SP, TRIG_KEY, TRIG_RUN
  } trig_t;

  typedef enum logic [2:0] {
    CH_CTRL, CH_ALARM1, CH_ALARM2, CH_ALARM_ANY,
    CH_LOOP_BREAK, CH_TIMER1, CH_TIMER2, CH_NONE
  } ch_func_t;

  typedef enum logic [1:0] {
    T_IDLE, T_PRI, T_SEC, T_DONE
  } tmr_state_t;

endpackage

// >>> timer_run_alarm_supervisor.sv
`include "sup_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_run_alarm_supervisor
  import sup_pkg::*;
#(
  parameter int NCH        = 4,
  parameter int TW         = 16,
  parameter int CYC_PER_MS = `SUP_CYC_PER_MS
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  // process side
  input  wire logic signed [15:0]    pv,
  input  wire logic signed [15:0]    setpoint,
  input  wire logic                  sensor_fault,
  input  wire logic [NAL-1:0]        alarm_cond,
  input  wire logic [NAL-1:0]        alarm_is_sensor_break,
  input  wire logic [NAL-1:0]        alarm_block_en,
  input  wire logic [6:0]            ctrl_pct_in,
  input  wire logic                  ctrl_demand,
  // front panel
  input  wire logic                  key_in,
  input  wire logic                  run_on_cmd,
  input  wire logic                  run_off_cmd,
  // configuration
  input  wire logic                  pid_mode,
  input  wire logic [6:0]            safe_output_percent,
  input  wire logic [7:0]            loop_break_interval,
  input  wire trig_t                 primary_timer_trigger_select,
  input  wire logic                  timer_time_base_select,
  input  wire logic                  timer_count_direction,
  input  wire logic                  timer_on_at_end,
  input  wire logic                  end_disable_en,
  input  wire logic [TW-1:0]         primary_interval,
  input  wire logic [TW-1:0]         secondary_interval,
  input  wire logic [NCH*FUNC_W-1:0] ch_func,
  // outputs
  output logic [NCH-1:0]             ch_out_r,
  output logic [6:0]                 ctrl_pct_r,
  output logic [NAL-1:0]             alarm_r,
  output logic                       loop_break_r,
  output logic                       run_lamp_r,
  output logic                       primary_timer_lamp_r,
  output logic                       secondary_timer_lamp_r,
  output logic [TW-1:0]              timer_count_r
);

  // ----------------------------------------
  // time base: ms, second and minute enables
  // ----------------------------------------
  logic [31:0] ms_div_r,  ms_div_nxt;
  logic [9:0]  ms_cnt_r,  ms_cnt_nxt;
  logic [5:0]  s_cnt_r,   s_cnt_nxt;
  logic [7:0]  fast_cnt_r, fast_cnt_nxt;
  logic        fast_ph_r, fast_ph_nxt;
  logic        ms_tick, s_tick, min_tick, unit_tick;

  always_comb begin
    ms_div_nxt   = ms_div_r + 32'h1;
    ms_cnt_nxt   = ms_cnt_r;
    s_cnt_nxt    = s_cnt_r;
    fast_cnt_nxt = fast_cnt_r;
    fast_ph_nxt  = fast_ph_r;
    ms_tick  = (ms_div_r == 32'(CYC_PER_MS - 1));
    s_tick   = ms_tick && (ms_cnt_r == 10'(`SUP_MS_PER_S - 1));
    min_tick = s_tick && (s_cnt_r == 6'(`SUP_S_PER_MIN - 1));
    if (ms_tick) begin
      ms_div_nxt   = 32'h0;
      ms_cnt_nxt   = s_tick ? 10'h0 : ms_cnt_r + 10'h1;
      fast_cnt_nxt = fast_cnt_r + 8'h1;
      if (fast_cnt_r == 8'(`SUP_FLASH_FAST_MS - 1)) begin
        fast_cnt_nxt = 8'h0;
        fast_ph_nxt  = ~fast_ph_r;
      end
    end
    if (s_tick) begin
      s_cnt_nxt = min_tick ? 6'h0 : s_cnt_r + 6'h1;
    end
    // one unit per second or minute as the base selects
    unit_tick = timer_time_base_select ? s_tick : min_tick;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_div_r   <= 32'h0;
      ms_cnt_r   <= 10'h0;
      s_cnt_r    <= 6'h0;
      fast_cnt_r <= 8'h0;
      fast_ph_r  <= 1'b0;
    end else begin
      ms_div_r   <= ms_div_nxt;
      ms_cnt_r   <= ms_cnt_nxt;
      s_cnt_r    <= s_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      fast_ph_r  <= fast_ph_nxt;
    end
  end

  // ----------------------------------------
  // front-panel key: press, short and long
  // ----------------------------------------
  logic [11:0] key_ms_r, key_ms_nxt;
  logic        key_q_r, key_q_nxt;
  logic        key_press, key_short, key_long;

  always_comb begin
    key_q_nxt  = key_in;
    key_ms_nxt = key_ms_r;
    key_press  = key_in && !key_q_r;
    key_long   = 1'b0;
    key_short  = 1'b0;
    if (key_press) begin
      key_ms_nxt = 12'h0;
    end else if (key_in && ms_tick &&
                 key_ms_r < 12'(`SUP_KEY_LONG_MS)) begin
      key_ms_nxt = key_ms_r + 12'h1;
      // long action fires while held, not at release
      key_long   = (key_ms_r == 12'(`SUP_KEY_LONG_MS - 1));
    end
    if (!key_in && key_q_r) begin
      key_short = (key_ms_r >= 12'(`SUP_KEY_SHORT_MS)) &&
                  (key_ms_r <  12'(`SUP_KEY_LONG_MS));
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_ms_r <= 12'h0;
      key_q_r  <= 1'b0;
    end else begin
      key_ms_r <= key_ms_nxt;
      key_q_r  <= key_q_nxt;
    end
  end

  // ----------------------------------------
  // timer sequence
  // ----------------------------------------
  tmr_state_t  st_r, st_nxt;
  logic        paused_r, paused_nxt;
  logic [TW-1:0] cnt_r, cnt_nxt, cur_ivl;
  logic        sp_reach, sp_reach_r, run_q_r, run_r;
  logic        start_ev, seq_end, key_ok;

  always_comb begin
    st_nxt     = st_r;
    paused_nxt = paused_r;
    cnt_nxt    = cnt_r;
    seq_end    = 1'b0;
    sp_reach   = (pv >= setpoint);
    key_ok     = (primary_timer_trigger_select == TRIG_KEY) && run_r;
    cur_ivl    = (st_r == T_SEC) ? secondary_interval : primary_interval;
    unique case (primary_timer_trigger_select)
      TRIG_SP:  start_ev = sp_reach && !sp_reach_r;
      TRIG_KEY: start_ev = key_press && key_ok;
      TRIG_RUN: start_ev = run_r && !run_q_r;
      TRIG_OFF: start_ev = 1'b0;
    endcase
    if (primary_timer_trigger_select == TRIG_OFF) begin
      st_nxt     = T_IDLE;
      paused_nxt = 1'b0;
      cnt_nxt    = '0;
    end else if (run_r) begin
      // timing free of control, but frozen with control enable off
      if (start_ev && (st_r == T_IDLE || st_r == T_DONE)) begin
        st_nxt     = T_PRI;
        cnt_nxt    = '0;
        paused_nxt = 1'b0;
      end else if (st_r == T_PRI || st_r == T_SEC) begin
        if (key_ok && key_long) begin
          st_nxt     = T_DONE;
          paused_nxt = 1'b0;
          seq_end    = 1'b1;
        end else if (key_ok && key_short) begin
          paused_nxt = ~paused_r;
        end else if (cnt_r >= cur_ivl) begin
          cnt_nxt = '0;
          if (st_r == T_PRI) begin
            st_nxt = T_SEC;
          end else begin
            st_nxt  = T_DONE;
            seq_end = 1'b1;
          end
        end else if (!paused_r && unit_tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= T_IDLE;
      paused_r   <= 1'b0;
      cnt_r      <= '0;
      sp_reach_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      paused_r   <= paused_nxt;
      cnt_r      <= cnt_nxt;
      sp_reach_r <= sp_reach;
    end
  end

  // ----------------------------------------
  // control enable and alarm blocking
  // ----------------------------------------
  logic           run_nxt;
  logic [NAL-1:0] blocked_r, blocked_nxt, alarm_eff;

  always_comb begin
    run_nxt = run_r;
    if (run_off_cmd) begin
      run_nxt = 1'b0;
    end else if (run_on_cmd) begin
      run_nxt = 1'b1;
    end
    // end of sequence wins over an operator turn-on
    if (seq_end && end_disable_en) begin
      run_nxt = 1'b0;
    end
    // block falls away once the condition has been seen clear
    blocked_nxt = blocked_r & alarm_cond;
    alarm_eff   = alarm_cond &
                  ~(blocked_r & alarm_block_en &
                    ~alarm_is_sensor_break);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_r     <= `SUP_RUN_RST;
      run_q_r   <= `SUP_RUN_RST;
      blocked_r <= `SUP_BLOCK_RST;
    end else begin
      run_r     <= run_nxt;
      run_q_r   <= run_r;
      blocked_r <= blocked_nxt;
    end
  end

  // ----------------------------------------
  // loop break detection
  // ----------------------------------------
  logic [7:0]         lbd_min_r, lbd_min_nxt;
  logic signed [15:0] pv_ref_r, pv_ref_nxt;
  logic               lbd_nxt, pv_moved;
  logic signed [16:0] pv_diff;

  always_comb begin
    lbd_min_nxt = lbd_min_r;
    pv_ref_nxt  = pv_ref_r;
    lbd_nxt     = loop_break_r;
    pv_diff     = 17'(pv) - 17'(pv_ref_r);
    pv_moved    = (pv_diff >= $signed({1'b0, `SUP_LBD_PV_DELTA})) ||
                  (pv_diff <= -$signed({1'b0, `SUP_LBD_PV_DELTA}));
    if (loop_break_interval == 8'h0 || !run_r) begin
      lbd_min_nxt = 8'h0;
      pv_ref_nxt  = pv;
      lbd_nxt     = 1'b0;
    end else if (pv_moved) begin
      lbd_min_nxt = 8'h0;
      pv_ref_nxt  = pv;
      lbd_nxt     = 1'b0;
    end else if (min_tick && !loop_break_r) begin
      if (lbd_min_r + 8'h1 >= loop_break_interval) begin
        lbd_nxt = 1'b1;
      end else begin
        lbd_min_nxt = lbd_min_r + 8'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lbd_min_r    <= 8'h0;
      pv_ref_r     <= 16'sh0;
      loop_break_r <= 1'b0;
    end else begin
      lbd_min_r    <= lbd_min_nxt;
      pv_ref_r     <= pv_ref_nxt;
      loop_break_r <= lbd_nxt;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic [NCH-1:0] ch_nxt;
  logic [6:0]     safe_pct, pct_nxt;
  logic           tmr1_on, tmr2_on, slow_on, lamp1_nxt, lamp2_nxt;
  logic [TW-1:0]  count_nxt;

  always_comb begin
    // off-range settings are coerced rather than refused
    if (pid_mode) begin
      safe_pct = (safe_output_percent > `SUP_PCT_FULL) ?
                 `SUP_PCT_FULL : safe_output_percent;
    end else begin
      safe_pct = (safe_output_percent >= `SUP_PCT_HALF) ?
                 `SUP_PCT_FULL : 7'h0;
    end
    pct_nxt = sensor_fault ? safe_pct : ctrl_pct_in;
    if (!run_r) begin
      pct_nxt = 7'h0;
    end
    slow_on = (ms_cnt_r < 10'(`SUP_FLASH_SLOW_MS));
    tmr1_on = timer_on_at_end ?
              (st_r == T_SEC || st_r == T_DONE) :
              (st_r == T_PRI);
    tmr2_on = (st_r == T_SEC);
    lamp1_nxt = 1'b0;
    lamp2_nxt = 1'b0;
    if (st_r == T_PRI) begin
      lamp1_nxt = paused_r ? fast_ph_r : slow_on;
    end else if (tmr1_on) begin
      lamp1_nxt = 1'b1;
    end
    if (st_r == T_SEC) begin
      lamp2_nxt = paused_r ? fast_ph_r : slow_on;
    end
    count_nxt = timer_count_direction ? cur_ivl - cnt_r : cnt_r;
    for (int i = 0; i < NCH; i++) begin
      unique case (ch_func_t'(ch_func[i*FUNC_W +: FUNC_W]))
        CH_CTRL:       ch_nxt[i] = sensor_fault ?
                                   (safe_pct >= `SUP_PCT_HALF) :
                                   ctrl_demand;
        CH_ALARM1:     ch_nxt[i] = alarm_eff[0];
        CH_ALARM2:     ch_nxt[i] = alarm_eff[1];
        CH_ALARM_ANY:  ch_nxt[i] = |alarm_eff;
        CH_LOOP_BREAK: ch_nxt[i] = loop_break_r;
        CH_TIMER1:     ch_nxt[i] = tmr1_on;
        CH_TIMER2:     ch_nxt[i] = tmr2_on;
        CH_NONE:       ch_nxt[i] = 1'b0;
      endcase
    end
    // control enable gates every channel
    ch_nxt = run_r ? ch_nxt : '0;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ch_out_r               <= '0;
      ctrl_pct_r             <= 7'h0;
      alarm_r                <= '0;
      run_lamp_r             <= `SUP_RUN_RST;
      primary_timer_lamp_r   <= 1'b0;
      secondary_timer_lamp_r <= 1'b0;
      timer_count_r          <= '0;
    end else begin
      ch_out_r               <= ch_nxt;
      ctrl_pct_r             <= pct_nxt;
      alarm_r                <= run_r ? alarm_eff : '0;
      // built from the next value so the lamp tracks run_r exactly
      run_lamp_r             <= run_nxt;
      primary_timer_lamp_r   <= lamp1_nxt;
      secondary_timer_lamp_r <= lamp2_nxt;
      timer_count_r          <= count_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> timer_run_alarm_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_run_alarm_supervisor_bench
  import sup_pkg::*;
;
  // one second of ms ticks with CYC_PER_MS shrunk to 1
  localparam int SEC = 1000;
  // ----
  // wiring
  // ----
  logic               clk_sys = 1'b0;
  logic               arst_n = 1'b0;
  logic signed [15:0] setpoint = 16'sh0064;
  logic signed [15:0] pv_goal = 16'sh0000;
  logic signed [15:0] pv;
  logic [1:0]         alarm_cond = 2'h3;
  logic [1:0]         alarm_is_sensor_break = 2'h2;
  logic [1:0]         alarm_block_en = 2'h3;
  logic [1:0]         alarm_r;
  logic [6:0]         ctrl_pct_in = 7'h11;
  logic [6:0]         safe_output_percent = 7'h00;
  logic [6:0]         ctrl_pct_r;
  logic [7:0]         loop_break_interval = 8'h00;
  trig_t              primary_timer_trigger_select = TRIG_OFF;
  logic [15:0]        primary_interval = 16'h0005;
  logic [15:0]        secondary_interval = 16'h0005;
  logic [15:0]        press_len = 16'h0000;
  logic [15:0]        timer_count_r;
  logic [11:0]        ch_func = {CH_LOOP_BREAK, CH_TIMER1, CH_ALARM1, CH_CTRL};
  logic [3:0]         ch_out_r;
  logic ctrl_demand = 1'b1, run_on_cmd = 1'b0, run_off_cmd = 1'b0;
  logic pid_mode = 1'b1, timer_time_base_select = 1'b1;
  logic timer_count_direction = 1'b0, timer_on_at_end = 1'b1;
  logic end_disable_en = 1'b0, fault_req = 1'b0, press_go = 1'b0;
  logic sensor_fault, key_in, loop_break_r, run_lamp_r;
  logic primary_timer_lamp_r, secondary_timer_lamp_r;
  int   failures = 0, checked = 0, cyc = 0;

  timer_run_alarm_supervisor #(.CYC_PER_MS(1)) uut (
    .clk_sys, .arst_n, .pv, .setpoint, .sensor_fault, .alarm_cond,
    .alarm_is_sensor_break, .alarm_block_en, .ctrl_pct_in, .ctrl_demand,
    .key_in, .run_on_cmd, .run_off_cmd, .pid_mode, .safe_output_percent,
    .loop_break_interval, .primary_timer_trigger_select,
    .timer_time_base_select, .timer_count_direction, .timer_on_at_end,
    .end_disable_en, .primary_interval, .secondary_interval, .ch_func,
    .ch_out_r, .ctrl_pct_r, .alarm_r, .loop_break_r, .run_lamp_r,
    .primary_timer_lamp_r, .secondary_timer_lamp_r, .timer_count_r
  );
  process_side_model plant (
    .clk_sys, .pv_goal, .fault_req, .press_go, .press_len, .pv,
    .sensor_fault, .key_in
  );

  always #2.5 clk_sys = ~clk_sys;
  // ----
  // helpers
  // ----
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic compare(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic set_run(input logic on);
    run_on_cmd = on;
    run_off_cmd = !on;
    idle(1);
    run_on_cmd = 1'b0;
    run_off_cmd = 1'b0;
    idle(4);
  endtask
  // key handled by the plant model; nba avoids racing its sampling edge
  task automatic press(input int n);
    press_len <= 16'(n);
    press_go <= 1'b1;
    idle(1);
    press_go <= 1'b0;
    idle(n + 2);
  endtask
  task automatic print_verdict;
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_block;
    set_run(1'b1);
    compare("alarm", 16'h0002, alarm_r);
    alarm_cond = 2'h2;
    idle(3);
    alarm_cond = 2'h3;
    idle(3);
    compare("alarm", 16'h0003, alarm_r);
    compare("ch_al", 1'b1, ch_out_r[1]);
  endtask
  task automatic t_gate;
    alarm_cond = 2'h0;
    idle(2);
    compare("ch_ctrl", 1'b1, ch_out_r[0]);
    compare("run_lamp", 1'b1, run_lamp_r);
    set_run(1'b0);
    compare("ch_out", 16'h0000, ch_out_r);
    compare("pct", 16'h0000, ctrl_pct_r);
    compare("run_lamp", 1'b0, run_lamp_r);
  endtask
  task automatic t_safe;
    set_run(1'b1);
    fault_req <= 1'b1;
    safe_output_percent = 7'h25;
    idle(4);
    compare("pct", 16'h0025, ctrl_pct_r);
    pid_mode = 1'b0;
    idle(2);
    compare("pct", 16'h0000, ctrl_pct_r);
    safe_output_percent = 7'h3c;
    idle(2);
    compare("pct", 16'h0064, ctrl_pct_r);
    pid_mode = 1'b1;
    fault_req <= 1'b0;
    idle(4);
    compare("pct", 16'h0011, ctrl_pct_r);
  endtask
  task automatic t_key;
    logic l;
    logic [15:0] c;
    int i;
    primary_timer_trigger_select = TRIG_KEY;
    end_disable_en = 1'b1;
    set_run(1'b0);
    press(5);
    compare("lamp1", 1'b0, primary_timer_lamp_r);
    set_run(1'b1);
    press(5);
    compare("ch_tmr", 1'b0, ch_out_r[2]);
    l = primary_timer_lamp_r;
    idle(SEC / 2);
    compare("lamp1", !l, primary_timer_lamp_r);
    for (i = 0; i < SEC && timer_count_r !== 16'h0001; i++) idle(1);
    idle(SEC - 5);
    compare("count", 16'h0001, timer_count_r);
    idle(10);
    compare("count", 16'h0002, timer_count_r);
    press(SEC + SEC / 2);
    c = timer_count_r;
    l = primary_timer_lamp_r;
    idle(SEC / 8);
    compare("fast", !l, primary_timer_lamp_r);
    idle(SEC);
    compare("paused", c, timer_count_r);
    press(SEC + SEC / 2);
    for (i = 0; i < 5 * SEC && ch_out_r[2] !== 1'b1; i++) idle(1);
    compare("ch_tmr", 1'b1, ch_out_r[2]);
    l = secondary_timer_lamp_r;
    idle(SEC / 2);
    compare("lamp2", !l, secondary_timer_lamp_r);
    compare("lamp1", 1'b1, primary_timer_lamp_r);
    press(3 * SEC + 100);
    compare("run_lamp", 1'b0, run_lamp_r);
    compare("lamp2", 1'b0, secondary_timer_lamp_r);
    end_disable_en = 1'b0;
  endtask
  task automatic t_sp;
    logic l;
    int i;
    primary_timer_trigger_select = TRIG_SP;
    timer_on_at_end = 1'b0;
    timer_count_direction = 1'b1;
    primary_interval = 16'h0002;
    secondary_interval = 16'h0000;
    set_run(1'b1);
    idle(SEC);
    compare("ch_tmr", 1'b0, ch_out_r[2]);
    pv_goal <= 16'sh0064;
    for (i = 0; i < 200 && ch_out_r[2] !== 1'b1; i++) idle(1);
    compare("ch_tmr", 1'b1, ch_out_r[2]);
    compare("count", 16'h0002, timer_count_r);
    l = primary_timer_lamp_r;
    idle(SEC / 2);
    compare("lamp1", !l, primary_timer_lamp_r);
    for (i = 0; i < 3 * SEC && ch_out_r[2] !== 1'b0; i++) idle(1);
    idle(2);
    compare("ch_tmr", 1'b0, ch_out_r[2]);
    compare("lamp1", 1'b0, primary_timer_lamp_r);
    primary_timer_trigger_select = TRIG_RUN;
    set_run(1'b0);
    set_run(1'b1);
    compare("ch_tmr", 1'b1, ch_out_r[2]);
    primary_timer_trigger_select = TRIG_OFF;
    idle(3);
    compare("lamp1", 1'b0, primary_timer_lamp_r);
    compare("ch_tmr", 1'b0, ch_out_r[2]);
  endtask
  // first minute tick is partial, so interval one fires at it
  task automatic t_lbd;
    int i;
    loop_break_interval = 8'h01;
    set_run(1'b1);
    compare("lbd", 1'b0, loop_break_r);
    for (i = 0; i < 61000 && loop_break_r !== 1'b1; i++) idle(1);
    idle(2);
    compare("lbd", 1'b1, loop_break_r);
    compare("ch_lbd", 1'b1, ch_out_r[3]);
    loop_break_interval = 8'h00;
    idle(2);
    compare("lbd", 1'b0, loop_break_r);
  endtask
  // ----
  // main sequence and hang guard
  // ----
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    idle(6);
    arst_n = 1'b1;
    idle(2);
    t_block();
    t_gate();
    t_safe();
    t_key();
    t_sp();
    t_lbd();
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> timer_run_alarm_supervisor_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module timer_run_alarm_supervisor_monitor
  import sup_pkg::*;
#(
  parameter int NCH = 4,
  parameter int TW  = 16
) (
  // clock and reset
  input wire logic           clk_sys,
  input wire logic           arst_n,
  // watched inputs
  input wire logic           sensor_fault,
  input wire logic [NAL-1:0] alarm_cond,
  input wire logic [NAL-1:0] alarm_is_sensor_break,
  input wire logic           run_on_cmd,
  input wire logic           run_off_cmd,
  input wire logic           pid_mode,
  input wire logic [6:0]     safe_output_percent,
  input wire logic [7:0]     loop_break_interval,
  input wire trig_t          primary_timer_trigger_select,
  input wire logic           end_disable_en,
  // watched outputs
  input wire logic [NCH-1:0] ch_out_r,
  input wire logic [6:0]     ctrl_pct_r,
  input wire logic [NAL-1:0] alarm_r,
  input wire logic           loop_break_r,
  input wire logic           run_lamp_r,
  input wire logic           primary_timer_lamp_r,
  input wire logic           secondary_timer_lamp_r
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_run_off_wins: assert property (run_off_cmd |=> !run_lamp_r)
    else $error("run lamp still lit after off");
  a_run_on_sets: assert property (
    run_on_cmd && !run_off_cmd && !end_disable_en |=> run_lamp_r)
    else $error("run lamp dark after on");
  a_off_all_dark: assert property (
    !run_lamp_r && (!run_on_cmd || run_off_cmd)
    |=> ch_out_r == '0 && alarm_r == '0 && ctrl_pct_r == 7'h00)
    else $error("output active with run off");
  a_safe_pid_pct: assert property (
    run_lamp_r && sensor_fault && pid_mode && safe_output_percent <= 7'h64
    |=> ctrl_pct_r == $past(safe_output_percent))
    else $error("safe percent not applied");
  a_safe_onoff_pct: assert property (
    run_lamp_r && sensor_fault && !pid_mode
    |=> ctrl_pct_r == 7'h00 || ctrl_pct_r == 7'h64)
    else $error("on/off safe value not 0 or 100");
  a_sensor_break_acts: assert property (
    run_lamp_r && alarm_cond[1] && alarm_is_sensor_break[1] |=> alarm_r[1])
    else $error("sensor break alarm held back");
  a_alarm_needs_cond: assert property (
    $rose(alarm_r[0]) |-> $past(alarm_cond[0]))
    else $error("alarm rose without condition");
  a_lbd_zero_off: assert property (
    (loop_break_interval == 8'h00) [*2] |-> !loop_break_r)
    else $error("loop break with interval zero");
  a_trig_off_idle: assert property (
    (primary_timer_trigger_select == TRIG_OFF) [*2]
    |=> !primary_timer_lamp_r && !secondary_timer_lamp_r)
    else $error("timer lamp lit with trigger off");
endmodule

bind timer_run_alarm_supervisor timer_run_alarm_supervisor_monitor #(
  .NCH(NCH),
  .TW(TW)
) mon (
  .clk_sys, .arst_n, .sensor_fault, .alarm_cond, .alarm_is_sensor_break,
  .run_on_cmd, .run_off_cmd, .pid_mode, .safe_output_percent,
  .loop_break_interval, .primary_timer_trigger_select, .end_disable_en,
  .ch_out_r, .ctrl_pct_r, .alarm_r, .loop_break_r, .run_lamp_r,
  .primary_timer_lamp_r, .secondary_timer_lamp_r
);
`default_nettype wire
